// file: rtl/drt_conv_top.sv
// Two-channel remote temperature conversion sequencer with result, threshold and alert registers
//
// What this block does
// - A started run converts channel 1 and then channel 2 with no further command.
// - A one-shot write or an automatic start converts both channels, results published only at the end.
// - The status busy bit is high exactly while a conversion run is in progress.
// - During a run the result registers keep the previous completed values.
// - Each channel integrates for 60 ms before its result is taken.
// - Results land in two data registers and are compared with four threshold registers in the same cycle.
// - A channel with no diode is measured like any other; the host ignores it.
// - The alert output is open drain and is only ever pulled low.
// - The serial clock is input only and the serial data line is driven only low.
// - The converter code is 12 bits wide before it is rounded to a temperature byte.
// - The standby bit stops the converter while registers and the serial port keep working.
// - A one-shot command runs one full conversion even with standby set.
// - A full run over both channels lasts 125 ms, then the converter idles until the next start.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "drt_map.svh"
module drt_conv_top #(
  parameter int         INTEG_CYC = `DRT_INTEG_MS * `DRT_CLK_KHZ,
  parameter int         CONV_CYC  = `DRT_CONV_MS * `DRT_CLK_KHZ,
  parameter int         MS_CYC    = `DRT_CLK_KHZ,
  parameter logic [6:0] SMB_ADDR  = `DRT_SMB_ADDR
) (
  // Clock, reset, enable
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // Register port
  input  wire drt_pkg::drt_byte_t reg_addr,
  input  wire drt_pkg::drt_byte_t reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output drt_pkg::drt_byte_t      reg_rdata,
  // Serial bus pins
  input  wire logic               smb_clk_in,
  input  wire logic               smb_data_in,
  output logic                    smb_data_o,
  output logic                    smb_data_oe,
  // Alert pin
  output logic                    alert_o,
  output logic                    alert_oe,
  // Converter core
  input  wire logic [11:0]        adc_code,
  output logic                    adc_ch_sel,
  output logic                    adc_integ
);
  import drt_pkg::*;

  localparam int TAIL_CYC = CONV_CYC - 2 * INTEG_CYC;

  generate
    if (INTEG_CYC < 1 || TAIL_CYC < 1 || MS_CYC < 1) begin : g_chk
      $error("drt_conv_top: CONV_CYC must exceed twice INTEG_CYC, all counts positive");
    end
  endgenerate

  // ----------------------------------------
  // State
  // ----------------------------------------
  drt_cv_t     cv_r;
  logic [31:0] tmr_r;
  logic        busy_r;
  logic        os_pend_r;
  logic        os_run_r;
  drt_byte_t   res1_r;
  drt_byte_t   res2_r;
  drt_byte_t   temp1_r;
  drt_byte_t   temp2_r;
  drt_byte_t   cfg_r;
  drt_byte_t   rate_r;
  drt_byte_t   t1hi_r;
  drt_byte_t   t1lo_r;
  drt_byte_t   t2hi_r;
  drt_byte_t   t2lo_r;
  logic [3:0]  alarm_r;
  logic [3:0]  alarm_nxt;
  logic        smb_wr_pend_r;
  logic        smb_rd_pend_r;
  drt_byte_t   smb_rdata_r;
  logic        smb_rvalid_r;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Round 1/16 degree code to whole degrees; saturate at the top of range
  function automatic drt_byte_t fmt_temp(input logic [11:0] code);
    logic [12:0] r;
    r = {code[11], code} + 13'h0008;
    fmt_temp = (r[12] != r[11]) ? 8'h7F : r[11:4];
  endfunction : fmt_temp

  function automatic logic t_gt(input drt_byte_t a, input drt_byte_t b);
    t_gt = $signed(a) > $signed(b);
  endfunction : t_gt

  function automatic drt_byte_t rd_val(input drt_byte_t a);
    unique case (a)
      `DRT_OFS_TEMP1:  rd_val = temp1_r;
      `DRT_OFS_TEMP2:  rd_val = temp2_r;
      `DRT_OFS_STATUS: rd_val = {busy_r, 3'h0, alarm_r};
      `DRT_OFS_CONFIG: rd_val = cfg_r;
      `DRT_OFS_RATE:   rd_val = rate_r;
      `DRT_OFS_T1HI:   rd_val = t1hi_r;
      `DRT_OFS_T1LO:   rd_val = t1lo_r;
      `DRT_OFS_T2HI:   rd_val = t2hi_r;
      `DRT_OFS_T2LO:   rd_val = t2lo_r;
      default:         rd_val = 8'h00;
    endcase
  endfunction : rd_val

  // ----------------------------------------
  // Serial slave
  // ----------------------------------------
  logic      scl_s;
  logic      sda_s;
  logic      smb_rd;
  logic      smb_wr;
  drt_byte_t smb_addr;
  drt_byte_t smb_wdata;

  drt_sync #(.W(2)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .d       ({smb_clk_in, smb_data_in}),
    .q       ({scl_s, sda_s})
  );

  drt_smb_slave u_smb (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ce       (ce),
    .scl      (scl_s),
    .sda      (sda_s),
    .dev_addr (SMB_ADDR),
    .rd_o     (smb_rd),
    .wr_o     (smb_wr),
    .addr_o   (smb_addr),
    .wdata_o  (smb_wdata),
    .rdata_i  (smb_rdata_r),
    .rvalid_i (smb_rvalid_r),
    .sda_oe   (smb_data_oe)
  );

  // ----------------------------------------
  // Access arbitration
  // ----------------------------------------
  // Plain port wins; a serial access waits, which is harmless since bus edges are far apart
  wire       plain_busy = reg_wr | reg_rd;
  wire       smb_wr_go  = smb_wr_pend_r & ~plain_busy;
  wire       smb_rd_go  = smb_rd_pend_r & ~plain_busy;
  wire       acc_wr     = reg_wr | smb_wr_go;
  drt_byte_t acc_addr;
  drt_byte_t acc_data;
  assign acc_addr = reg_wr ? reg_addr : smb_addr;
  assign acc_data = reg_wr ? reg_wdata : smb_wdata;

  wire wr_cfg  = acc_wr & (acc_addr == `DRT_OFS_CONFIG);
  wire wr_rate = acc_wr & (acc_addr == `DRT_OFS_RATE);
  wire wr_t1hi = acc_wr & (acc_addr == `DRT_OFS_T1HI);
  wire wr_t1lo = acc_wr & (acc_addr == `DRT_OFS_T1LO);
  wire wr_t2hi = acc_wr & (acc_addr == `DRT_OFS_T2HI);
  wire wr_t2lo = acc_wr & (acc_addr == `DRT_OFS_T2LO);
  wire wr_os   = acc_wr & (acc_addr == `DRT_OFS_ONESHOT);
  wire st_clr  = (reg_rd & (reg_addr == `DRT_OFS_STATUS)) | (smb_rd_go & (smb_addr == `DRT_OFS_STATUS));

  // ----------------------------------------
  // Sequencer decode
  // ----------------------------------------
  wire        standby   = cfg_r[`DRT_CFG_STBY];
  wire [31:0] idle_lim  = 32'(rate_r) * 32'(MS_CYC);
  wire        auto_go   = ~standby & (tmr_r >= idle_lim);
  wire        start     = (cv_r == CV_IDLE) & (os_pend_r | auto_go);
  wire        integ_end = tmr_r == 32'(INTEG_CYC - 1);
  wire        tail_end  = tmr_r == 32'(TAIL_CYC - 1);
  wire        abort     = standby & ~os_run_r & (cv_r != CV_IDLE);
  wire        publish   = (cv_r == CV_TAIL) & tail_end & ~abort;
  wire [3:0]  alarm_hit;

  // New results are checked against all four limits as they are published
  assign alarm_hit = {4{publish}} & {t_gt(t2lo_r, res2_r), t_gt(res2_r, t2hi_r),
                                     t_gt(t1lo_r, res1_r), t_gt(res1_r, t1hi_r)};
  // A hit in the clearing cycle survives the clear
  assign alarm_nxt = (alarm_r & ~{4{st_clr}}) | alarm_hit;

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cv_r       <= CV_IDLE;
      tmr_r      <= 32'h0;
      busy_r     <= 1'b0;
      os_run_r   <= 1'b0;
      adc_ch_sel <= 1'b0;
      adc_integ  <= 1'b0;
      res1_r     <= `DRT_RST_TEMP;
      res2_r     <= `DRT_RST_TEMP;
    end else if (ce) begin
      if (abort) begin
        cv_r      <= CV_IDLE;
        tmr_r     <= 32'h0;
        busy_r    <= 1'b0;
        adc_integ <= 1'b0;
      end else begin
        unique case (cv_r)
          CV_IDLE: if (start) begin
            cv_r       <= CV_CH1;
            tmr_r      <= 32'h0;
            busy_r     <= 1'b1;
            os_run_r   <= os_pend_r;
            adc_ch_sel <= 1'b0;
            adc_integ  <= 1'b1;
          end else tmr_r <= tmr_r + 32'h1;
          CV_CH1: if (integ_end) begin
            // Taken whether or not a diode is fitted
            res1_r     <= fmt_temp(adc_code);
            cv_r       <= CV_CH2;
            tmr_r      <= 32'h0;
            adc_ch_sel <= 1'b1;
          end else tmr_r <= tmr_r + 32'h1;
          CV_CH2: if (integ_end) begin
            res2_r    <= fmt_temp(adc_code);
            cv_r      <= CV_TAIL;
            tmr_r     <= 32'h0;
            adc_integ <= 1'b0;
          end else tmr_r <= tmr_r + 32'h1;
          CV_TAIL: if (tail_end) begin
            cv_r     <= CV_IDLE;
            tmr_r    <= 32'h0;
            busy_r   <= 1'b0;
            os_run_r <= 1'b0;
          end else tmr_r <= tmr_r + 32'h1;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Results, status and alert
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      temp1_r    <= `DRT_RST_TEMP;
      temp2_r    <= `DRT_RST_TEMP;
      alarm_r    <= 4'h0;
      alert_oe   <= 1'b0;
      os_pend_r  <= 1'b0;
      alert_o    <= 1'b0;
      smb_data_o <= 1'b0;
    end else if (ce) begin
      // Open-drain pins never drive high
      alert_o    <= 1'b0;
      smb_data_o <= 1'b0;
      if (publish) begin
        temp1_r <= res1_r;
        temp2_r <= res2_r;
      end
      alarm_r   <= alarm_nxt;
      alert_oe  <= (|alarm_nxt) & ~cfg_r[`DRT_CFG_AMASK];
      os_pend_r <= (os_pend_r & ~start) | wr_os;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_r  <= `DRT_RST_CONFIG;
      rate_r <= `DRT_RST_RATE;
      t1hi_r <= `DRT_RST_THI;
      t1lo_r <= `DRT_RST_TLO;
      t2hi_r <= `DRT_RST_THI;
      t2lo_r <= `DRT_RST_TLO;
    end else if (ce) begin
      if (wr_cfg) cfg_r <= acc_data;
      if (wr_rate) rate_r <= acc_data;
      if (wr_t1hi) t1hi_r <= acc_data;
      if (wr_t1lo) t1lo_r <= acc_data;
      if (wr_t2hi) t2hi_r <= acc_data;
      if (wr_t2lo) t2lo_r <= acc_data;
    end
  end

  // ----------------------------------------
  // Read paths
  // ----------------------------------------
  // Both ports keep answering in standby
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata     <= 8'h00;
      smb_rdata_r   <= 8'h00;
      smb_rvalid_r  <= 1'b0;
      smb_wr_pend_r <= 1'b0;
      smb_rd_pend_r <= 1'b0;
    end else if (ce) begin
      reg_rdata     <= reg_rd ? rd_val(reg_addr) : 8'h00;
      smb_rvalid_r  <= smb_rd_go;
      if (smb_rd_go) smb_rdata_r <= rd_val(smb_addr);
      smb_wr_pend_r <= (smb_wr_pend_r & ~smb_wr_go) | smb_wr;
      smb_rd_pend_r <= (smb_rd_pend_r & ~smb_rd_go) | smb_rd;
    end
  end
endmodule : drt_conv_top

// file: rtl/drt_map.svh
// Register map, reset values, field positions and timing figures of the conversion block
`ifndef DRT_MAP_SVH
`define DRT_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DRT_OFS_TEMP1   8'h00
`define DRT_OFS_TEMP2   8'h01
`define DRT_OFS_STATUS  8'h02
`define DRT_OFS_CONFIG  8'h03
`define DRT_OFS_RATE    8'h04
`define DRT_OFS_T1HI    8'h05
`define DRT_OFS_T1LO    8'h06
`define DRT_OFS_T2HI    8'h07
`define DRT_OFS_T2LO    8'h08
`define DRT_OFS_ONESHOT 8'h0F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DRT_CFG_STBY    6
`define DRT_CFG_AMASK   7
`define DRT_ST_BUSY     7

// ----------------------------------------
// Reset values and serial address
// ----------------------------------------
`define DRT_RST_TEMP    8'h00
`define DRT_RST_CONFIG  8'h00
`define DRT_RST_RATE    8'h00
`define DRT_RST_THI     8'h7F
`define DRT_RST_TLO     8'hC9
`define DRT_SMB_ADDR    7'h2A

// ----------------------------------------
// Timing
// ----------------------------------------
`define DRT_CLK_KHZ     10000
`define DRT_INTEG_MS    60
`define DRT_CONV_MS     125

`endif

// file: rtl/drt_pkg.sv
// Types shared by the conversion block and its serial slave
package drt_pkg;
  typedef logic [7:0] drt_byte_t;
  typedef enum logic [1:0] {CV_IDLE, CV_CH1, CV_CH2, CV_TAIL} drt_cv_t;
  typedef enum logic [2:0] {SB_IDLE, SB_ADDR, SB_ACKA, SB_WR, SB_ACKW, SB_RD, SB_ACKR} drt_sb_t;
endpackage : drt_pkg

// file: rtl/drt_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module drt_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  generate
    if (W < 1) begin : g_chk
      $error("drt_sync: W must be at least 1");
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_r <= '1;
      q      <= '1;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : drt_sync

// file: rtl/drt_smb_slave.sv
// Serial management bus slave: byte write, byte read, send byte, receive byte
`timescale 1ns/1ps
module drt_smb_slave
  import drt_pkg::*;
(
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Synchronised bus lines
  input  wire logic         scl,
  input  wire logic         sda,
  input  wire logic [6:0]   dev_addr,
  // Register access
  output logic              rd_o,
  output logic              wr_o,
  output drt_pkg::drt_byte_t addr_o,
  output drt_pkg::drt_byte_t wdata_o,
  input  wire drt_pkg::drt_byte_t rdata_i,
  input  wire logic         rvalid_i,
  // Open-drain data pull
  output logic              sda_oe
);
  drt_sb_t   st_r;
  logic      scl_q_r;
  logic      sda_q_r;
  logic [3:0] cnt_r;
  logic      rw_r;
  logic      first_r;
  drt_byte_t tx_r;

  wire scl_rise = scl & ~scl_q_r;
  wire scl_fall = ~scl & scl_q_r;
  wire start_c  = scl & scl_q_r & sda_q_r & ~sda;
  wire stop_c   = scl & scl_q_r & ~sda_q_r & sda;
  wire byte_end = cnt_r == 4'h8;
  wire addr_hit = wdata_o[7:1] == dev_addr;

  // Clock line is only ever sampled; data line only pulled low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r    <= SB_IDLE;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      cnt_r   <= 4'h0;
      rw_r    <= 1'b0;
      first_r <= 1'b0;
      tx_r    <= 8'h00;
      addr_o  <= 8'h00;
      wdata_o <= 8'h00;
      rd_o    <= 1'b0;
      wr_o    <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (ce) begin
      scl_q_r <= scl;
      sda_q_r <= sda;
      rd_o    <= 1'b0;
      wr_o    <= 1'b0;
      if (rvalid_i) tx_r <= rdata_i;
      if (start_c) begin
        st_r    <= SB_ADDR;
        cnt_r   <= 4'h0;
        first_r <= 1'b1;
        sda_oe  <= 1'b0;
      end else if (stop_c) begin
        st_r   <= SB_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (st_r == SB_ADDR || st_r == SB_WR) begin
          wdata_o <= {wdata_o[6:0], sda};
          cnt_r   <= cnt_r + 4'h1;
        end else if (st_r == SB_ACKR) begin
          // Master acknowledge asks for the same register again
          if (sda) st_r <= SB_IDLE;
          else begin
            st_r <= SB_ACKA;
            rd_o <= 1'b1;
          end
        end
      end else if (scl_fall) begin
        unique case (st_r)
          SB_ADDR: if (byte_end) begin
            if (addr_hit) begin
              st_r   <= SB_ACKA;
              sda_oe <= 1'b1;
              rw_r   <= wdata_o[0];
              rd_o   <= wdata_o[0];
            end else st_r <= SB_IDLE;
          end
          SB_ACKA: if (rw_r) begin
            st_r   <= SB_RD;
            sda_oe <= ~tx_r[7];
            cnt_r  <= 4'h1;
          end else begin
            st_r   <= SB_WR;
            sda_oe <= 1'b0;
            cnt_r  <= 4'h0;
          end
          SB_WR: if (byte_end) begin
            st_r   <= SB_ACKW;
            sda_oe <= 1'b1;
            if (first_r) addr_o <= wdata_o;
            else wr_o <= 1'b1;
          end
          SB_ACKW: begin
            st_r    <= SB_WR;
            sda_oe  <= 1'b0;
            cnt_r   <= 4'h0;
            first_r <= 1'b0;
          end
          SB_RD: if (byte_end) begin
            st_r   <= SB_ACKR;
            sda_oe <= 1'b0;
          end else begin
            sda_oe <= ~tx_r[6];
            tx_r   <= {tx_r[6:0], 1'b0};
            cnt_r  <= cnt_r + 4'h1;
          end
          SB_ACKR, SB_IDLE: ;
        endcase
      end
    end
  end
endmodule : drt_smb_slave

// file: sim/drt_conv_assertions.sv
// Port checker for the conversion block, bound to its top module
`timescale 1ns/1ps
`include "drt_map.svh"
module drt_conv_chk #(
  parameter int INTEG_CYC = 20,
  parameter int CONV_CYC  = 50
) (
  // Clock, reset, enable
  input wire logic               ref_clk,
  input wire logic               rst,
  input wire logic               ce,
  // Register port
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire drt_pkg::drt_byte_t reg_addr,
  input wire drt_pkg::drt_byte_t reg_wdata,
  input wire drt_pkg::drt_byte_t reg_rdata,
  // Pins and converter core
  input wire logic               smb_data_o,
  input wire logic               alert_o,
  input wire logic               alert_oe,
  input wire logic               adc_ch_sel,
  input wire logic               adc_integ
);
  import drt_pkg::*;
  localparam int OS_MAX = CONV_CYC + 3;
  // Results publish a fixed tail after integration ends; one cycle of slack each way
  localparam int T_LO   = CONV_CYC - 2 * INTEG_CYC - 1;
  localparam int T_HI   = T_LO + 2;
  logic [15:0] icnt_r;
  logic [15:0] tcnt_r;
  drt_byte_t   cfg_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      icnt_r <= '0;
      tcnt_r <= '0;
      cfg_r  <= `DRT_RST_CONFIG;
    end else if (ce) begin
      icnt_r <= adc_integ ? icnt_r + 16'h0001 : 16'h0000;
      tcnt_r <= adc_integ ? 16'h0000 : (tcnt_r == 16'hFFFF ? tcnt_r : tcnt_r + 16'h0001);
      if (reg_wr && reg_addr == `DRT_OFS_CONFIG) begin
        cfg_r <= reg_wdata;
      end
    end
  end
  sequence s_ch2_phase;
    (adc_ch_sel && adc_integ) [*8];
  endsequence
  // A status read clears at once; a mask write acts one cycle after it lands
  sequence s_clear_cause;
    ($past(reg_rd) && $past(reg_addr) == `DRT_OFS_STATUS) ||
    ($past(reg_wr, 2) && $past(reg_addr, 2) == `DRT_OFS_CONFIG);
  endsequence
  chk_ch1_first: assert property ($rose(adc_integ) |-> !adc_ch_sel)
    else $error("run did not start on channel 1");
  chk_ch2_follows: assert property ($rose(adc_ch_sel) |-> s_ch2_phase)
    else $error("channel 2 integration cut short");
  chk_ch1_length: assert property ($rose(adc_ch_sel) |-> icnt_r == 16'(INTEG_CYC))
    else $error("channel 1 integration length wrong");
  chk_both_length: assert property ($fell(adc_integ) |-> icnt_r == 16'(2 * INTEG_CYC))
    else $error("two-channel integration length wrong");
  chk_alert_opendrain: assert property (!alert_o)
    else $error("alert pin driven high");
  chk_data_opendrain: assert property (!smb_data_o)
    else $error("data pin driven high");
  chk_alert_publish: assert property ($rose(alert_oe) |-> tcnt_r >= 16'(T_LO) && tcnt_r <= 16'(T_HI))
    else $error("alert rose outside result publish");
  chk_alert_clear: assert property ($fell(alert_oe) |-> s_clear_cause)
    else $error("alert released without status read or mask");
  chk_cfg_kept: assert property (reg_rd && reg_addr == `DRT_OFS_CONFIG |=> reg_rdata == cfg_r)
    else $error("configuration read back wrong");
  chk_oneshot_run: assert property (reg_wr && reg_addr == `DRT_OFS_ONESHOT |-> ##[1:OS_MAX] $rose(adc_integ))
    else $error("one-shot did not start a run");
endmodule : drt_conv_chk

bind drt_conv_top drt_conv_chk #(.INTEG_CYC(INTEG_CYC), .CONV_CYC(CONV_CYC)) drt_conv_chk_i (
  .ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .smb_data_o(smb_data_o), .alert_o(alert_o),
  .alert_oe(alert_oe), .adc_ch_sel(adc_ch_sel), .adc_integ(adc_integ));

// file: sim/drt_host_model.sv
// Serial bus host model: makes the clock, drives and reads back the data wire
`timescale 1ns/1ps
module drt_host_model (
  // Bus lines
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  localparam int HALF = 400;
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end
  // Clock rests high between frames; a released data line is lifted by the pull-up
  task automatic start_c;
    sda_drv = 1'b1;
    #HALF scl = 1'b1;
    #HALF sda_drv = 1'b0;
    #HALF scl = 1'b0;
  endtask : start_c
  task automatic stop_c;
    sda_drv = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda_drv = 1'b1;
    #HALF;
  endtask : stop_c
  task automatic put_bit(input logic b);
    sda_drv = b;
    #HALF scl = 1'b1;
    #HALF scl = 1'b0;
  endtask : put_bit
  // Sampled mid-way through the high phase, well after the device's change after the fall
  task automatic get_bit(output logic b);
    sda_drv = 1'b1;
    #HALF scl = 1'b1;
    #(HALF / 2) b = sda_line;
    #(HALF / 2) scl = 1'b0;
  endtask : get_bit
  task automatic send_byte(input logic [7:0] v, output logic nak);
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(nak);
  endtask : send_byte
  task automatic recv_byte(output logic [7:0] v);
    for (int i = 7; i >= 0; i--) get_bit(v[i]);
    put_bit(1'b1);
  endtask : recv_byte
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] cmd, input logic [7:0] d,
                           output logic [2:0] nak);
    start_c();
    send_byte({dev, 1'b0}, nak[2]);
    send_byte(cmd, nak[1]);
    send_byte(d, nak[0]);
    stop_c();
  endtask : write_reg
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] cmd, output logic [7:0] d,
                          output logic [2:0] nak);
    start_c();
    send_byte({dev, 1'b0}, nak[2]);
    send_byte(cmd, nak[1]);
    start_c();
    send_byte({dev, 1'b1}, nak[0]);
    recv_byte(d);
    stop_c();
  endtask : read_reg
endmodule : drt_host_model

// file: sim/drt_conv_top_test.sv
// Self-checking bench for the conversion block
`timescale 1ns/1ps
`include "drt_map.svh"
module drt_conv_top_test;
  import drt_pkg::*;
  localparam int INTEG = 20;
  localparam int CONV  = 50;
  logic        ref_clk, rst, ce, reg_wr, reg_rd, scl, sda_drv;
  logic        smb_data_o, smb_data_oe, alert_o, alert_oe, adc_ch_sel, adc_integ;
  logic [11:0] code1, code2, adc_code;
  logic [2:0]  nak;
  drt_byte_t   reg_addr, reg_wdata, reg_rdata, sdat;
  drt_byte_t   ofs[7] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0A};
  drt_byte_t   rv[7]  = '{8'h00, 8'h00, 8'h7F, 8'hC9, 8'h7F, 8'hC9, 8'h00};
  int          err_total, compares, cyc;
  wire         sda_line = sda_drv & (smb_data_oe ? smb_data_o : 1'b1);

  drt_conv_top #(.INTEG_CYC(INTEG), .CONV_CYC(CONV), .MS_CYC(4)) drt_conv_top_i (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .smb_clk_in(scl), .smb_data_in(sda_line),
    .smb_data_o(smb_data_o), .smb_data_oe(smb_data_oe), .alert_o(alert_o), .alert_oe(alert_oe),
    .adc_code(adc_code), .adc_ch_sel(adc_ch_sel), .adc_integ(adc_integ));
  drt_host_model drt_host_model_i (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Converter core answers with the code of whichever channel is selected
  always @(posedge ref_clk) begin
    adc_code <= adc_ch_sel ? code2 : code1;
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic chk8(input string n, input drt_byte_t e, input drt_byte_t g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk8
  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask : chk1
  task automatic wr(input drt_byte_t a, input drt_byte_t d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input drt_byte_t a, input drt_byte_t e);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk8($sformatf("reg %h", a), e, reg_rdata);
  endtask : rd
  task automatic wait_integ(input logic v);
    for (int i = 0; i < 200 && adc_integ !== v; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk1("integrate level", v, adc_integ);
  endtask : wait_integ
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    {rst, ce, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b11, 2'b00, 16'h0000};
    {code1, code2, adc_code, err_total, compares, cyc} = {12'h190, 12'h320, 12'h000, 96'h0};
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`DRT_OFS_STATUS, 8'h80);
    rd(`DRT_OFS_TEMP1, 8'h00);
    foreach (ofs[i]) rd(ofs[i], rv[i]);
    wr(`DRT_OFS_TEMP1, 8'h55);
    repeat (CONV + 5) @(posedge ref_clk);
    rd(`DRT_OFS_TEMP1, 8'h19);
    rd(`DRT_OFS_TEMP2, 8'h32);
    $display("test auto runs done, mismatches %0d", err_total);
    wait_integ(1'b1);
    wait_integ(1'b0);
    wr(`DRT_OFS_CONFIG, 8'h40);
    code1 <= 12'hE70;
    code2 <= 12'h7FF;
    repeat (CONV + 10) @(posedge ref_clk);
    chk1("integrate idle", 1'b0, adc_integ);
    rd(`DRT_OFS_CONFIG, 8'h40);
    rd(`DRT_OFS_TEMP1, 8'h19);
    rd(`DRT_OFS_STATUS, 8'h00);
    $display("test standby done, mismatches %0d", err_total);
    wr(`DRT_OFS_ONESHOT, 8'h01);
    repeat (2) @(posedge ref_clk);
    rd(`DRT_OFS_STATUS, 8'h80);
    repeat (CONV - 12) @(posedge ref_clk);
    rd(`DRT_OFS_TEMP1, 8'h19);
    rd(`DRT_OFS_STATUS, 8'h80);
    repeat (12) @(posedge ref_clk);
    rd(`DRT_OFS_TEMP1, 8'hE7);
    rd(`DRT_OFS_TEMP2, 8'h7F);
    rd(`DRT_OFS_STATUS, 8'h00);
    $display("test one-shot done, mismatches %0d", err_total);
    #13;
    drt_host_model_i.write_reg(`DRT_SMB_ADDR, `DRT_OFS_T1HI, 8'h10, nak);
    chk8("write acks", 8'h00, {5'h00, nak});
    drt_host_model_i.write_reg(`DRT_SMB_ADDR ^ 7'h01, `DRT_OFS_T1LO, 8'h00, nak);
    chk8("foreign acks", 8'h07, {5'h00, nak});
    drt_host_model_i.write_reg(`DRT_SMB_ADDR, `DRT_OFS_T2LO, 8'h20, nak);
    drt_host_model_i.read_reg(`DRT_SMB_ADDR, `DRT_OFS_T1HI, sdat, nak);
    chk8("serial read", 8'h10, sdat);
    chk8("read acks", 8'h00, {5'h00, nak});
    @(posedge ref_clk);
    code1 <= 12'h190;
    code2 <= 12'h190;
    rd(`DRT_OFS_T1LO, 8'hC9);
    rd(`DRT_OFS_T2LO, 8'h20);
    wr(`DRT_OFS_ONESHOT, 8'h01);
    repeat (CONV + 5) @(posedge ref_clk);
    chk1("alert pull", 1'b1, alert_oe);
    chk1("alert level", 1'b0, alert_o);
    rd(`DRT_OFS_STATUS, 8'h09);
    chk1("alert released", 1'b0, alert_oe);
    rd(`DRT_OFS_STATUS, 8'h00);
    $display("test alarms done, mismatches %0d", err_total);
    wr(`DRT_OFS_ONESHOT, 8'h01);
    repeat (INTEG / 2) @(posedge ref_clk);
    ce <= 1'b0;
    repeat (INTEG) @(posedge ref_clk);
    #1 chk1("frozen channel", 1'b0, adc_ch_sel);
    chk1("frozen integrate", 1'b1, adc_integ);
    @(posedge ref_clk);
    ce <= 1'b1;
    repeat (INTEG) @(posedge ref_clk);
    #1 chk1("thawed channel", 1'b1, adc_ch_sel);
    $display("test clock enable done, mismatches %0d", err_total);
    stop_test();
  end
endmodule : drt_conv_top_test
